/* File: tpc_pkg.sv */
// Constants and types shared by the test-pattern and line-trim block.
package tpc_pkg;
   // Register indices; the byte address of each register is four times its index.
   localparam logic [7:0] IDX_A_VFP = 8'h3A;
   localparam logic [7:0] IDX_B_VFP = 8'h3B;
   localparam logic [7:0] IDX_PAT = 8'h3C;
   localparam logic [7:0] IDX_RTRIM = 8'h3D;
   localparam logic [7:0] IDX_LTRIM = 8'h3E;
   localparam logic [7:0] IDX_MODE = 8'h40;
   localparam logic [7:0] IDX_TIME = 8'h41;
   localparam logic [7:0] IDX_ACTIVE = 8'h42;
   localparam logic [7:0] IDX_STATUS = 8'h43;
   localparam logic [7:0] IDX_NONE = 8'hFF;
   // Field positions.
   localparam int PAT_A_BIT = 4;
   localparam int PAT_B_BIT = 0;
   localparam int MODE_LR_BIT = 2;
   localparam int TIME_HFP_LSB = 8;
   localparam int TIME_VBP_LSB = 16;
   localparam int ACT_V_LSB = 16;
   // Channel mode value that gives channel B its own timing.
   localparam logic [1:0] MODE_SPLIT = 2'h2;
   // Reset values.
   localparam logic [11:0] RST_HACT = 12'h010;
   localparam logic [11:0] RST_VACT = 12'h008;
   // Fixed sync widths of the pattern generator, and the output buffer depth.
   localparam logic [12:0] HSYNC_CLOCKS = 13'h0004;
   localparam logic [12:0] VSYNC_LINES = 13'h0002;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   typedef struct packed {
      logic vs;
      logic hs;
      logic de;
      logic last;
      logic [23:0] pixel;
   } tpc_word_type;
endpackage

/* File: tpc_timing_if.sv */
// Settings and pixel word between the control logic and one pattern generator.
`timescale 1ns/10ps
interface tpc_timing_if;
   logic en;
   logic step;
   logic [7:0] vfp;
   logic [7:0] vbp;
   logic [7:0] hfp;
   logic [7:0] hbp;
   logic [11:0] hact;
   logic [11:0] vact;
   tpc_pkg::tpc_word_type word;
   modport gen (input en, step, vfp, vbp, hfp, hbp, hact, vact, output word);
   modport ctl (output en, step, vfp, vbp, hfp, hbp, hact, vact, input word);
endinterface

/* File: tpc_pattern_gen.sv */
// Raster counter that produces the test pattern of one channel.
`timescale 1ns/10ps
module tpc_pattern_gen (
   input wire logic hclk,
   input wire logic hresetn,
   tpc_timing_if.gen tif
);
   typedef struct packed {
      logic [12:0] h;
      logic [12:0] v;
   } tpc_gen_state_type;
   tpc_gen_state_type st, next_st;
   logic [12:0] h_sync_at, h_total, v_sync_at, v_total;

   // Line order: active, front porch, sync, back porch; frames likewise in lines.
   always_comb begin
      h_sync_at = 13'(tif.hact) + 13'(tif.hfp);
      h_total = h_sync_at + tpc_pkg::HSYNC_CLOCKS + 13'(tif.hbp);
      v_sync_at = 13'(tif.vact) + 13'(tif.vfp);
      v_total = v_sync_at + tpc_pkg::VSYNC_LINES + 13'(tif.vbp);
      next_st = st;
      if (!tif.en) begin
         next_st = '0;
      end else if (tif.step) begin
         if (13'(st.h + 13'h0001) >= h_total) begin
            next_st.h = '0;
            next_st.v = (13'(st.v + 13'h0001) >= v_total) ? '0 : 13'(st.v + 13'h0001);
         end else begin
            next_st.h = 13'(st.h + 13'h0001);
         end
      end
      tif.word.de = (st.h < 13'(tif.hact)) && (st.v < 13'(tif.vact));
      tif.word.last = tif.word.de && (st.h == 13'(tif.hact) - 13'h0001);
      tif.word.hs = (st.h >= h_sync_at) && (st.h < h_sync_at + tpc_pkg::HSYNC_CLOCKS);
      tif.word.vs = (st.v >= v_sync_at) && (st.v < v_sync_at + tpc_pkg::VSYNC_LINES);
      tif.word.pixel = {st.h[7:0], st.v[7:0], st.h[7:0] ^ st.v[7:0]};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_HFP_GAP: assert property (tif.en && $rose(tif.word.hs) |-> st.h == h_sync_at)
      else $error("hsync did not start after the horizontal front porch");
   AST_HBP_GAP: assert property (tif.en && $past(tif.en) && $changed(st.h) && st.h == '0
      |-> $past(st.h) == $past(h_total) - 13'h0001)
      else $error("line did not end after the horizontal back porch");
   AST_VFP_GAP: assert property (tif.en && $rose(tif.word.vs) |-> st.v == v_sync_at)
      else $error("vsync did not start after the vertical front porch");
   AST_VBP_GAP: assert property (tif.en && $past(tif.en) && $changed(st.v) && st.v == '0
      |-> $past(st.v) == $past(v_total) - 13'h0001)
      else $error("frame did not end after the vertical back porch");
endmodule

/* File: tpc_top.sv */
// Test-pattern generation and left/right line trimming with an AHB-Lite register slave.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Channel A's pattern, and channel B's when it shares timing, puts a_vfp_lines lines between active video and vsync.
// - Channel B's pattern uses b_vfp_lines as its front porch only when the channel mode is 10.
// - While a_pattern_on is set channel A carries a generated pattern; after reset it is clear.
// - While b_pattern_on is set and the channel mode is 10, channel B carries a generated pattern.
// - In left/right mode the first right_half_trim pixels of each channel B line are dropped.
// - In left/right mode the last left_half_trim pixels of each channel A line after the first since reset are dropped.
// - Both trim values are ignored unless left/right mode is set to 1.
// - The pattern puts the programmed number of lines between vsync end and active video.
// - The pattern puts the programmed number of clocks between active line end and hsync.
// - The pattern puts the programmed number of clocks between hsync end and active data.
module tpc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [1:0] in_valid,
   input wire logic [1:0][23:0] in_pixel,
   input wire logic [1:0] in_last,
   output logic [1:0] in_ready,
   input wire logic [1:0] out_ready,
   output logic [1:0] out_valid,
   output logic [1:0][23:0] out_pixel,
   output logic [1:0] out_last,
   output logic [1:0] out_de,
   output logic [1:0] out_hsync,
   output logic [1:0] out_vsync
);
   typedef struct packed {
      logic [7:0] a_vfp_lines;
      logic [7:0] b_vfp_lines;
      logic a_pattern_on;
      logic b_pattern_on;
      logic [7:0] right_half_trim;
      logic [7:0] left_half_trim;
      logic [1:0] chan_mode;
      logic lr_pixels;
      logic [7:0] vbp;
      logic [7:0] hfp;
      logic [7:0] hbp;
      logic [11:0] hact;
      logic [11:0] vact;
      logic dph_wr;
      logic [7:0] dph_idx;
      logic [31:0] rdata;
      logic ready_q;
      logic [1:0][11:0] idx;
      logic [11:0] a_prev_len;
      logic [1:0][1:0] count;
      logic [1:0] has_data;
      logic [1:0] room;
      logic [1:0] in_ready;
      tpc_pkg::tpc_word_type [1:0] e0;
      tpc_pkg::tpc_word_type [1:0] e1;
   } tpc_state_type;

   tpc_state_type st, next_st;
   tpc_pkg::tpc_word_type [1:0] gword;
   tpc_pkg::tpc_word_type [1:0] src;
   logic [1:0] pat_eff, accept, keep, push, pop, src_valid, tail_end;
   logic addr_ok;
   logic [7:0] a_idx;
   logic [31:0] rd;
   logic split;

   tpc_timing_if tif[2] ();

   assign split = (st.chan_mode == tpc_pkg::MODE_SPLIT);
   assign pat_eff[0] = st.a_pattern_on;
   assign pat_eff[1] = split ? st.b_pattern_on : st.a_pattern_on;

   genvar g;
   for (g = 0; g < 2; g++) begin : gen_ch
      assign tif[g].en = pat_eff[g];
      assign tif[g].step = pat_eff[g] && st.room[g];
      assign tif[g].vbp = st.vbp;
      assign tif[g].hfp = st.hfp;
      assign tif[g].hbp = st.hbp;
      assign tif[g].hact = st.hact;
      assign tif[g].vact = st.vact;
      assign gword[g] = tif[g].word;
      tpc_pattern_gen u_gen (
         .hclk(hclk),
         .hresetn(hresetn),
         .tif(tif[g])
      );
   end
   assign tif[0].vfp = st.a_vfp_lines;
   // Channel B falls back to channel A's porch unless it runs its own timing.
   assign tif[1].vfp = split ? st.b_vfp_lines : st.a_vfp_lines;

   always_comb begin
      next_st = st;
      next_st.ready_q = 1'b1;
      // Write data phase; only implemented bits are stored.
      if (st.dph_wr) begin
         unique case (st.dph_idx)
            tpc_pkg::IDX_A_VFP: next_st.a_vfp_lines = hwdata[7:0];
            tpc_pkg::IDX_B_VFP: next_st.b_vfp_lines = hwdata[7:0];
            tpc_pkg::IDX_PAT: begin
               next_st.a_pattern_on = hwdata[tpc_pkg::PAT_A_BIT];
               next_st.b_pattern_on = hwdata[tpc_pkg::PAT_B_BIT];
            end
            tpc_pkg::IDX_RTRIM: next_st.right_half_trim = hwdata[7:0];
            tpc_pkg::IDX_LTRIM: next_st.left_half_trim = hwdata[7:0];
            tpc_pkg::IDX_MODE: begin
               next_st.chan_mode = hwdata[1:0];
               next_st.lr_pixels = hwdata[tpc_pkg::MODE_LR_BIT];
            end
            tpc_pkg::IDX_TIME: begin
               next_st.hbp = hwdata[7:0];
               next_st.hfp = hwdata[tpc_pkg::TIME_HFP_LSB +: 8];
               next_st.vbp = hwdata[tpc_pkg::TIME_VBP_LSB +: 8];
            end
            tpc_pkg::IDX_ACTIVE: begin
               next_st.hact = hwdata[11:0];
               next_st.vact = hwdata[tpc_pkg::ACT_V_LSB +: 12];
            end
            default: ;
         endcase
      end
      // Address phase; reads see a write that finishes in the same cycle.
      addr_ok = hsel && hready && htrans[1];
      a_idx = (~|haddr[31:10] && ~|haddr[1:0]) ? haddr[9:2] : tpc_pkg::IDX_NONE;
      next_st.dph_wr = addr_ok && hwrite;
      next_st.dph_idx = a_idx;
      rd = '0;
      unique case (a_idx)
         tpc_pkg::IDX_A_VFP: rd[7:0] = next_st.a_vfp_lines;
         tpc_pkg::IDX_B_VFP: rd[7:0] = next_st.b_vfp_lines;
         tpc_pkg::IDX_PAT: begin
            rd[tpc_pkg::PAT_A_BIT] = next_st.a_pattern_on;
            rd[tpc_pkg::PAT_B_BIT] = next_st.b_pattern_on;
         end
         tpc_pkg::IDX_RTRIM: rd[7:0] = next_st.right_half_trim;
         tpc_pkg::IDX_LTRIM: rd[7:0] = next_st.left_half_trim;
         tpc_pkg::IDX_MODE: begin
            rd[1:0] = next_st.chan_mode;
            rd[tpc_pkg::MODE_LR_BIT] = next_st.lr_pixels;
         end
         tpc_pkg::IDX_TIME: rd[23:0] = {next_st.vbp, next_st.hfp, next_st.hbp};
         tpc_pkg::IDX_ACTIVE: begin
            rd[11:0] = next_st.hact;
            rd[tpc_pkg::ACT_V_LSB +: 12] = next_st.vact;
         end
         tpc_pkg::IDX_STATUS: rd[3:0] = {gword[1].vs, gword[1].de, gword[0].vs, gword[0].de};
         default: ;
      endcase
      if (addr_ok && !hwrite) begin
         next_st.rdata = rd;
      end
      // Per-channel trimming and two-entry buffering.
      for (int c = 0; c < 2; c++) begin
         accept[c] = in_valid[c] && st.in_ready[c];
         keep[c] = 1'b1;
         if (st.lr_pixels) begin
            // The tail trim uses the previous line's length, so the first line passes whole.
            if (c == 1 && st.idx[1] < 12'(st.right_half_trim)) begin
               keep[c] = 1'b0;
            end
            if (c == 0 && st.a_prev_len != '0 && 13'(st.idx[0]) + 13'(st.left_half_trim)
                  >= 13'(st.a_prev_len)) begin
               keep[c] = 1'b0;
            end
         end
         if (accept[c]) begin
            next_st.idx[c] = in_last[c] ? '0 : 12'(st.idx[c] + 12'h001);
            if (c == 0 && in_last[c]) begin
               next_st.a_prev_len = 12'(st.idx[0] + 12'h001);
            end
         end
         // A trimmed tail would take the line-end marker with it, so the last kept pixel carries it.
         tail_end[c] = 1'b0;
         if (c == 0 && st.lr_pixels && st.a_prev_len != '0 && 13'(st.idx[0])
               + 13'(st.left_half_trim) + 13'h0001 == 13'(st.a_prev_len)) begin
            tail_end[c] = 1'b1;
         end
         src[c] = pat_eff[c] ? gword[c] : {3'b001, in_last[c] || tail_end[c], in_pixel[c]};
         src_valid[c] = pat_eff[c] ? 1'b1 : (accept[c] && keep[c]);
         push[c] = src_valid[c] && st.room[c];
         pop[c] = (st.count[c] != '0) && out_ready[c];
         if (st.count[c] == 2'h2) begin
            if (pop[c]) begin
               next_st.e0[c] = st.e1[c];
            end
         end else if (st.count[c] == 2'h1 && !pop[c]) begin
            if (push[c]) begin
               next_st.e1[c] = src[c];
            end
         end else if (push[c]) begin
            next_st.e0[c] = src[c];
         end
         next_st.count[c] = 2'(st.count[c] + {1'b0, push[c]} - {1'b0, pop[c]});
         next_st.room[c] = next_st.count[c] < tpc_pkg::BUF_DEPTH;
         // Kept as its own flag so that out_valid leaves straight from a flip-flop.
         next_st.has_data[c] = (next_st.count[c] != '0);
         // Received video is drained and discarded while the pattern owns the output.
         next_st.in_ready[c] = next_st.room[c] || next_pat(next_st, c);
      end
   end

   function automatic logic next_pat(input tpc_state_type s, input int c);
      logic r;
      r = s.a_pattern_on;
      if (c == 1 && s.chan_mode == tpc_pkg::MODE_SPLIT) begin
         r = s.b_pattern_on;
      end
      return r;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
         st.hact <= tpc_pkg::RST_HACT;
         st.vact <= tpc_pkg::RST_VACT;
         st.dph_idx <= tpc_pkg::IDX_NONE;
         st.ready_q <= 1'b1;
         st.room <= 2'h3;
         st.in_ready <= 2'h3;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata = st.rdata;
   assign hreadyout = st.ready_q;
   assign hresp = 1'b0;
   assign in_ready = st.in_ready;
   for (g = 0; g < 2; g++) begin : gen_out
      assign out_valid[g] = st.has_data[g];
      assign out_pixel[g] = st.e0[g].pixel;
      assign out_last[g] = st.e0[g].last;
      assign out_de[g] = st.e0[g].de;
      assign out_hsync[g] = st.e0[g].hs;
      assign out_vsync[g] = st.e0[g].vs;
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   AST_TRIM_HEAD: assert property (accept[1] && st.lr_pixels && !pat_eff[1]
      && st.idx[1] < 12'(st.right_half_trim) |-> !push[1] ##1 st.count[1] <= $past(st.count[1]))
      else $error("channel B head pixel was not trimmed");
   AST_TRIM_TAIL: assert property (accept[0] && st.lr_pixels && !pat_eff[0]
      && st.a_prev_len != '0 && st.left_half_trim != '0
      && 13'(st.idx[0]) + 13'(st.left_half_trim) >= 13'(st.a_prev_len) |-> !push[0])
      else $error("channel A tail pixel was not trimmed");
   AST_TRIM_OFF: assert property (accept[0] && !st.lr_pixels && !pat_eff[0]
      |-> push[0] ##1 out_valid[0])
      else $error("trim applied outside left/right mode");
   AST_ZERO_TRIM: assert property (accept[1] && st.right_half_trim == '0 && !pat_eff[1]
      |-> push[1])
      else $error("zero trim dropped a pixel");
   AST_PAT_A: assert property (st.a_pattern_on && st.room[0] |-> push[0] ##1 out_valid[0])
      else $error("channel A pattern not produced");
   AST_PAT_DRAIN: assert property (st.a_pattern_on ##1 st.a_pattern_on |-> in_ready[0])
      else $error("input not drained while pattern shown");
   AST_B_SHARED: assert property (st.chan_mode != tpc_pkg::MODE_SPLIT
      |-> pat_eff[1] == st.a_pattern_on && tif[1].vfp == st.a_vfp_lines)
      else $error("channel B ignored shared timing");
   AST_B_OWN: assert property (st.chan_mode == tpc_pkg::MODE_SPLIT
      |-> tif[1].vfp == st.b_vfp_lines && pat_eff[1] == st.b_pattern_on)
      else $error("channel B own porch not used");
   AST_RSVD: assert property (addr_ok && !hwrite && a_idx == tpc_pkg::IDX_PAT
      |=> hrdata[7:5] == 3'h0 && hrdata[3:1] == 3'h0 && hrdata[31:8] == 24'h000000)
      else $error("reserved pattern bits read nonzero");
   AST_BUF_CAP: assert property (push[0] && !pop[0]
      |=> st.count[0] == 2'($past(st.count[0]) + 2'h1))
      else $error("buffer count did not follow a push");
   // Entry 0 drives the pins, so a stalled word must not move until it is taken.
   AST_HOLD_STALL_A: assert property (out_valid[0] && !out_ready[0]
      |=> out_valid[0] && $stable(out_pixel[0]) && $stable(out_last[0]))
      else $error("stalled channel A word changed");
   AST_HOLD_STALL_B: assert property (out_valid[1] && !out_ready[1]
      |=> out_valid[1] && $stable(out_pixel[1]) && $stable(out_last[1]))
      else $error("stalled channel B word changed");
   AST_FULL_REFUSE: assert property (st.count[1] == tpc_pkg::BUF_DEPTH && !pat_eff[1]
      |-> !in_ready[1])
      else $error("input offered room while the buffer was full");
   AST_TAIL_MARK: assert property (accept[0] && keep[0] && !pat_eff[0] && tail_end[0]
      && st.count[0] == '0 |=> out_last[0])
      else $error("trimmed line lost its end marker");

   COV_HEAD_TRIM: cover property (accept[1] && st.lr_pixels && !keep[1]);
   COV_TAIL_TRIM: cover property (accept[0] && st.lr_pixels && !keep[0]);
   COV_PAT_FRAME: cover property (pat_eff[0] && $rose(gword[0].vs));
   COV_BUF_FULL: cover property (st.count[0] == tpc_pkg::BUF_DEPTH && !out_ready[0]);
   COV_TAIL_MARK: cover property (accept[0] && keep[0] && tail_end[0]);
endmodule

/* File: tpc_host_model.sv */
// Behavioural host that streams lines of video into one input channel.
`timescale 1ns/10ps
module tpc_host_model (
   input wire logic hclk,
   input wire logic in_ready,
   output logic valid,
   output logic [23:0] pixel,
   output logic last
);
   initial begin
      valid = 1'b0;
      pixel = 24'h000000;
      last = 1'b0;
   end
   // Each pixel is held until it is taken; once released the data lines show
   // the inverse of the last pixel so that stale data cannot pass for new data.
   task automatic send_line(input int n, input logic [23:0] base, input int gap);
      for (int i = 0; i < n; i++) begin
         valid <= 1'b1;
         pixel <= base + 24'(i);
         last <= (i == n - 1);
         do @(posedge hclk); while (in_ready !== 1'b1);
         if (gap > 0 || i == n - 1) begin
            valid <= 1'b0;
            last <= 1'b0;
            pixel <= ~(base + 24'(i));
         end
         // A line end with no gap still lets one edge pass, so the next line never
         // raises valid in the same step that lowered it.
         repeat ((gap == 0 && i == n - 1) ? 1 : gap) @(posedge hclk);
      end
   endtask
endmodule

/* File: tpc_top_test.sv */
// Self-checking bench for register access, line trimming and pattern timing.
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %0t: got %0h expected %0h", $time, a, e); end end
module tpc_top_test;
   localparam int HACT = 4;
   localparam int HFP = 2;
   localparam int HBP = 1;
   localparam int VACT = 2;
   localparam int VBP = 1;
   localparam int LW = HACT + HFP + 4 + HBP;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, stall, pchk;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, in_ready, out_ready, out_valid, out_last, out_de, out_hsync, out_vsync;
   logic [1:0][23:0] out_pixel;
   wire logic [1:0] in_valid, in_last;
   wire logic [1:0][23:0] in_pixel;
   logic [24:0] exq[2][$];
   logic [24:0] ev;
   logic pde[2], phs[2], pvs[2];
   int k[2], dfall[2], hfall[2], vfall[2], vrise[2], lastde[2], nvs[2];
   int vfp[2] = '{3, 5};
   int n_errors = 0, checks_done = 0, cyc = 0, seed;
   logic [7:0] wi[6] = '{8'h3A, 8'h3D, 8'h3C, 8'h3C, 8'h41, 8'h50};
   logic [31:0] wd[6] = '{32'h5A, 32'hA5, 32'hEE, 32'h01, 32'hFF030201, 32'hFF};
   logic [31:0] we[6] = '{32'h5A, 32'hA5, 32'h00, 32'h01, 32'h00030201, 32'h00};
   assign hready = hreadyout;
   tpc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid), .in_pixel(in_pixel),
      .in_last(in_last), .in_ready(in_ready), .out_ready(out_ready), .out_valid(out_valid),
      .out_pixel(out_pixel), .out_last(out_last), .out_de(out_de), .out_hsync(out_hsync),
      .out_vsync(out_vsync));
   tpc_host_model host_a (.hclk(hclk), .in_ready(in_ready[0]), .valid(in_valid[0]),
      .pixel(in_pixel[0]), .last(in_last[0]));
   tpc_host_model host_b (.hclk(hclk), .in_ready(in_ready[1]), .valid(in_valid[1]),
      .pixel(in_pixel[1]), .last(in_last[1]));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic results();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One single AHB transfer; read data is taken at the end of the data phase.
   task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] d,
         output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h000000, idx, 2'h0};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   // Two lines of six pixels on each channel, with the sink stalled at first.
   task automatic traffic(input logic trim);
      for (int ln = 0; ln < 2; ln++)
         for (int i = 0; i < 6; i++) begin
            // Channel A's tail trim moves the line-end marker onto its last kept pixel.
            if (!trim || i < 4) exq[0].push_back({1'(i == (trim ? 3 : 5)), 24'(ln * 16 + i)});
            if (!trim || i >= 2) exq[1].push_back({1'(i == 5), 24'h800000 + 24'(ln * 16 + i)});
         end
      stall <= 1'b1;
      fork
         for (int ln = 0; ln < 2; ln++) host_a.send_line(6, 24'(ln * 16), 0);
         for (int ln = 0; ln < 2; ln++) host_b.send_line(6, 24'h800000 + 24'(ln * 16), 1);
         begin
            repeat (8) @(posedge hclk);
            stall <= 1'b0;
         end
      join
      for (int w = 0; w < 300 && exq[0].size() + exq[1].size() > 0; w++) @(posedge hclk);
      `CHK(exq[0].size() + exq[1].size(), 0)
   endtask
   always @(posedge hclk) begin
      out_ready <= stall ? 2'h0 : {($random(seed) % 4) != 0, ($random(seed) % 4) != 0};
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         $display("CHECK FAILED %0t: timeout", $time);
         results();
      end
   end
   always @(posedge hclk) begin
      for (int c = 0; c < 2; c++) begin
         if (hresetn && out_valid[c] === 1'b1 && out_ready[c] && !pchk) begin
            if (exq[c].size() == 0) begin
               n_errors++;
               $display("CHECK FAILED %0t: unexpected pixel", $time);
            end else begin
               ev = exq[c].pop_front();
               `CHK(out_pixel[c], ev[23:0])
               `CHK(out_last[c], ev[24])
               `CHK({out_de[c], out_hsync[c], out_vsync[c]}, 3'b100)
            end
         end else if (hresetn && out_valid[c] === 1'b1 && out_ready[c]) begin
            // Timing is measured in popped words, so sink stalls do not disturb it.
            if (pde[c] && !out_de[c]) dfall[c] = k[c];
            if (!phs[c] && out_hsync[c] && dfall[c] >= 0) begin
               `CHK(k[c] - dfall[c], HFP)
               dfall[c] = -1;
            end
            if (phs[c] && !out_hsync[c]) hfall[c] = k[c];
            if (!pde[c] && out_de[c] && hfall[c] >= 0) `CHK(k[c] - hfall[c], HBP)
            if (!pde[c] && out_de[c] && vfall[c] >= 0) begin
               `CHK(k[c] - vfall[c], VBP * LW)
               vfall[c] = -1;
            end
            if (pvs[c] && !out_vsync[c]) vfall[c] = k[c];
            if (!pvs[c] && out_vsync[c]) begin
               if (lastde[c] >= 0) `CHK(k[c] - lastde[c] - 1, HFP + 4 + HBP + vfp[c] * LW)
               if (vrise[c] >= 0) `CHK(k[c] - vrise[c], LW * (VACT + vfp[c] + 2 + VBP))
               vrise[c] = k[c];
               nvs[c]++;
            end
            if (out_de[c]) lastde[c] = k[c];
            pde[c] = out_de[c];
            phs[c] = out_hsync[c];
            pvs[c] = out_vsync[c];
            k[c]++;
         end
      end
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h00000000;
      out_ready = 2'h0;
      stall = 1'b0;
      pchk = 1'b0;
      seed = 72;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         ahb(1'b0, 8'h3A + 8'(i), 32'h0, rd);
         `CHK(rd, 32'h00000000)
      end
      for (int i = 0; i < 6; i++) begin
         ahb(1'b1, wi[i], wd[i], rd);
         ahb(1'b0, wi[i], 32'h0, rd);
         `CHK({hresp, rd}, {1'b0, we[i]})
      end
      ahb(1'b1, 8'h3D, 32'h0, rd);
      ahb(1'b1, tpc_pkg::IDX_MODE, 32'h4, rd);
      traffic(1'b0);
      ahb(1'b1, 8'h3D, 32'h2, rd);
      ahb(1'b1, 8'h3E, 32'h2, rd);
      ahb(1'b1, tpc_pkg::IDX_MODE, 32'h0, rd);
      traffic(1'b0);
      ahb(1'b1, tpc_pkg::IDX_ACTIVE, 32'h00020004, rd);
      ahb(1'b1, tpc_pkg::IDX_MODE, 32'h4, rd);
      traffic(1'b1);
      ahb(1'b1, tpc_pkg::IDX_TIME, 32'h00010201, rd);
      ahb(1'b1, 8'h3A, 32'h3, rd);
      ahb(1'b1, 8'h3B, 32'h5, rd);
      ahb(1'b1, tpc_pkg::IDX_MODE, 32'h2, rd);
      for (int c = 0; c < 2; c++) begin
         k[c] = 0;
         {dfall[c], hfall[c], vfall[c], vrise[c], lastde[c], nvs[c]} = {6{-32'sd1}};
         nvs[c] = 0;
         {pde[c], phs[c], pvs[c]} = 3'b000;
      end
      pchk = 1'b1;
      ahb(1'b1, tpc_pkg::IDX_PAT, 32'h11, rd);
      host_a.send_line(6, 24'h0000AA, 0);
      for (int w = 0; w < 3000 && (nvs[0] < 3 || nvs[1] < 3); w++) @(posedge hclk);
      `CHK(nvs[0] >= 3 && nvs[1] >= 3, 1'b1)
      results();
   end
endmodule
